// ==== hdl/pls_supervisor.v ====
`timescale 1ns/100ps
`default_nettype none
`include "pls_defs.vh"
// What this block does
// [RULE1] Latch mode: output undervoltage latches converter off
// [RULE2] Hiccup mode: undervoltage gives timed retry cycles
// [RULE3] Host must break an endless hiccup loop
// [RULE4] Input lockout stops all but lockout detectors
// [RULE5] Level 1 holds until both lockouts clear
// [RULE6] Bias or aux faults, hard thermal start reset
// [RULE7] Stop bias and aux, blank, restart bias
// [RULE8] Level 3 keeps converter off until enable low
// [RULE9] Latch triggers: UV, sync error, OV, OC
// [RULE10] Latch holds while enable stays high
// [RULE11] Level 4 gives one off period then retry
// [RULE12] Persistent cause repeats the off period
// [RULE13] Hiccup triggers: UV, sync error, soft thermal
// [RULE14] Bad frequency resistor: revalidate forever, main off
// [RULE15] Validation loop keeps raising resistor fault flag
// [RULE16] Resistor checked only before bias ready; code checks it after bias_power_good, before main start
// [RULE17] Four consecutive limit pairs declare over-current
// [RULE18] Most severe active level governs
// [RULE19] Off and blanking periods from loaded counters
module pls_supervisor (
    input wire clk_sys,
    input wire resetn,
    input wire input_undervoltage_lockout,
    input wire input_overvoltage_lockout,
    input wire bias_overcurrent,
    input wire bias_overvoltage,
    input wire bias_undervoltage,
    input wire aux_undervoltage,
    input wire hard_thermal_shutdown,
    input wire soft_thermal_shutdown,
    input wire output_undervoltage,
    input wire output_overvoltage,
    input wire sync_input_error,
    input wire cbc_limit_high,
    input wire cbc_limit_low,
    input wire pwm_cycle,
    input wire bias_power_good,
    input wire freq_resistor_valid,
    input wire freq_check_done,
    input wire internal_enable,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg bias_enable,
    output reg aux_enable,
    output reg main_enable,
    output reg freq_check_start,
    output reg irq
);
    // ======================================================
    // States
    localparam [2:0] ST_OFF = 3'h0;
    localparam [2:0] ST_BLANK = 3'h1;
    localparam [2:0] ST_BIAS_UP = 3'h2;
    localparam [2:0] ST_FCHECK = 3'h3;
    localparam [2:0] ST_READY = 3'h4;
    localparam [2:0] ST_RUN = 3'h5;
    localparam [2:0] ST_LATCHED = 3'h6;
    localparam [2:0] ST_HICCUP = 3'h7;

    // ======================================================
    // Helpers
    // Register write strobe aimed at one offset
    function wr_hit;
        input wr;
        input [7:0] addr;
        input [7:0] offs;
        begin
            wr_hit = wr && (addr == offs);
        end
    endfunction

    // Rails stay up in every state but level 1 and blanking
    function rails_on;
        input [2:0] st;
        begin
            rails_on = (st != ST_OFF) && (st != ST_BLANK);
        end
    endfunction

    // Six-bit fields read back zero-extended
    function [7:0] pad6;
        input [5:0] val;
        begin
            pad6 = {2'h0, val};
        end
    endfunction

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [7:0] ctrl_ff;
    reg [5:0] flags_ff;
    reg [5:0] mask_ff;
    reg [5:0] ev;
    reg tmr_start;
    reg [15:0] tmr_load;
    wire tmr_busy;
    wire tmr_done;
    wire oc_trip;
    reg oc_hold_ff;
    reg [7:0] nxt_rdata;

    wire latch_mode_select = ctrl_ff[`PLS_CTRL_LATCH];
    // ======================================================
    // Fault sorting
    wire lvl1 = input_undervoltage_lockout | input_overvoltage_lockout; // [RULE4]
    wire lvl2 = bias_overcurrent | bias_overvoltage | bias_undervoltage
        | aux_undervoltage | hard_thermal_shutdown; // [RULE6]
    wire main_active = (state_ff == ST_RUN);
    wire uv_or_sync = output_undervoltage | sync_input_error;
    wire lvl3 = main_active & ((uv_or_sync & latch_mode_select)
        | output_overvoltage | oc_trip | oc_hold_ff); // [RULE9] [RULE1]
    wire lvl4 = main_active & ((uv_or_sync & ~latch_mode_select)
        | soft_thermal_shutdown); // [RULE13] [RULE2]

    // Live status; levels read as they stand this cycle
    wire [7:0] status_byte = {2'h0, lvl1, lvl2, main_active, tmr_busy, oc_hold_ff,
        bias_power_good};

    pls_oc_detect u_oc (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clr(~main_active),
        .cbc_high(cbc_limit_high),
        .cbc_low(cbc_limit_low),
        .pwm_cycle(pwm_cycle),
        .oc_trip(oc_trip)
    );

    pls_timer u_tmr (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .start(tmr_start),
        .load_val(tmr_load),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // ======================================================
    // Sequencer; lower level number wins
    always @* begin
        nxt_state = state_ff;
        tmr_start = 1'b0;
        tmr_load = 16'h0000;
        ev = 6'h00;
        if (lvl1) begin
            nxt_state = ST_OFF; // [RULE4] [RULE18]
            if (state_ff != ST_OFF)
                ev[`PLS_IRQ_L1] = 1'b1;
        end else begin
            case (state_ff)
            ST_OFF: begin
                // Leave only once both lockouts are gone
                nxt_state = ST_BIAS_UP; // [RULE5]
            end
            ST_BLANK: begin
                if (tmr_done)
                    nxt_state = ST_BIAS_UP; // [RULE7]
            end
            default: begin
                if (lvl2) begin
                    nxt_state = ST_BLANK; // [RULE6] [RULE7] [RULE18]
                    tmr_start = 1'b1;
                    tmr_load = `PLS_BLANK_CYC; // [RULE19]
                    ev[`PLS_IRQ_L2] = 1'b1;
                end else begin
                    case (state_ff)
                    ST_BIAS_UP: begin
                        if (bias_power_good)
                            nxt_state = ST_FCHECK;
                    end
                    ST_FCHECK: begin
                        // Main stays idle; resistor is rechecked until valid
                        if (freq_check_done && freq_resistor_valid)
                            nxt_state = ST_READY; // [RULE14] [RULE16]
                        else if (freq_check_done)
                            ev[`PLS_IRQ_RFREQ] = 1'b1; // [RULE15]
                    end
                    ST_READY: begin
                        if (internal_enable)
                            nxt_state = ST_RUN;
                    end
                    ST_RUN: begin
                        if (lvl3) begin
                            nxt_state = ST_LATCHED; // [RULE8] [RULE18]
                            ev[`PLS_IRQ_L3] = 1'b1;
                        end else if (lvl4) begin
                            nxt_state = ST_HICCUP; // [RULE11]
                            tmr_start = 1'b1;
                            tmr_load = `PLS_HICCUP_CYC; // [RULE19]
                            ev[`PLS_IRQ_L4] = 1'b1;
                        end else if (!internal_enable) begin
                            nxt_state = ST_READY;
                        end
                    end
                    ST_LATCHED: begin
                        // Acts like waiting for a new enable edge
                        if (!internal_enable)
                            nxt_state = ST_READY; // [RULE10]
                    end
                    ST_HICCUP: begin
                        // Retry; a lasting cause re-trips next cycle in run.
                        // No exit by itself: the host must drop the enable.
                        if (!internal_enable)
                            nxt_state = ST_READY; // [RULE3]
                        else if (tmr_done)
                            nxt_state = ST_RUN; // [RULE12] [RULE11]
                    end
                    default: nxt_state = ST_OFF;
                    endcase
                end
            end
            endcase
        end
        if (oc_trip)
            ev[`PLS_IRQ_OC] = 1'b1; // [RULE17]
    end

    // ======================================================
    // State register
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_OFF;
            oc_hold_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            // Holds a trip one more cycle so the latch decision sees it
            oc_hold_ff <= oc_trip & main_active;
        end
    end

    // ======================================================
    // Rail and converter enables
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bias_enable <= 1'b0;
            aux_enable <= 1'b0;
            main_enable <= 1'b0;
            freq_check_start <= 1'b0;
        end else begin
            // Taken from nxt_state so pins move on the same edge as the state
            bias_enable <= rails_on(nxt_state); // [RULE4] [RULE7]
            aux_enable <= rails_on(nxt_state); // [RULE7]
            main_enable <= (nxt_state == ST_RUN); // [RULE8] [RULE14]
            freq_check_start <= (nxt_state == ST_FCHECK)
                && ((state_ff != ST_FCHECK) || freq_check_done); // [RULE14]
        end
    end

    // ======================================================
    // Control, mask and sticky flags
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= `PLS_CTRL_RST;
            flags_ff <= 6'h00;
            mask_ff <= `PLS_MASK_RST;
            irq <= 1'b0;
        end else begin
            if (wr_hit(reg_wr, reg_addr, `PLS_ADDR_CTRL))
                ctrl_ff <= reg_wdata;
            if (wr_hit(reg_wr, reg_addr, `PLS_ADDR_MASK))
                mask_ff <= reg_wdata[5:0];
            // Set beats write-one-to-clear in the same cycle
            if (wr_hit(reg_wr, reg_addr, `PLS_ADDR_IRQ))
                flags_ff <= (flags_ff & ~reg_wdata[5:0]) | ev;
            else
                flags_ff <= flags_ff | ev;
            // Irq lags the flags by one cycle to keep the pin registered
            irq <= |(flags_ff & mask_ff);
        end
    end

    // ======================================================
    // Read port; data stand one cycle, zero otherwise
    always @* begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
            `PLS_ADDR_CTRL: nxt_rdata = ctrl_ff;
            `PLS_ADDR_STAT: nxt_rdata = status_byte;
            `PLS_ADDR_IRQ: nxt_rdata = pad6(flags_ff);
            `PLS_ADDR_MASK: nxt_rdata = pad6(mask_ff);
            `PLS_ADDR_STATE: nxt_rdata = {5'h00, state_ff};
            default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= nxt_rdata;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/pls_defs.vh ====
`ifndef PLS_DEFS_VH
`define PLS_DEFS_VH
// ==========================================================
// Register offsets (8-bit address, 8-bit data)
`define PLS_ADDR_CTRL 8'h00
`define PLS_ADDR_STAT 8'h01
`define PLS_ADDR_IRQ 8'h02
`define PLS_ADDR_MASK 8'h03
`define PLS_ADDR_STATE 8'h04
// ==========================================================
// Control fields
`define PLS_CTRL_LATCH 0
`define PLS_CTRL_RST 8'h00
// ==========================================================
// Interrupt bits
`define PLS_IRQ_RFREQ 0
`define PLS_IRQ_OC 1
`define PLS_IRQ_L1 2
`define PLS_IRQ_L2 3
`define PLS_IRQ_L3 4
`define PLS_IRQ_L4 5
`define PLS_IRQ_W 6
`define PLS_MASK_RST 6'h00
// ==========================================================
// Timing: 100 us at the 50 ns clock, sized for the 16-bit timer
`define PLS_HICCUP_CYC 16'h07D0
`define PLS_BLANK_CYC 16'h07D0
`define PLS_OC_PAIRS 3'h4
`endif

// ==== hdl/pls_timer.v ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Load-and-count-down timer, done pulses on expiry
module pls_timer (
    input wire clk_sys,
    input wire resetn,
    input wire start,
    input wire [15:0] load_val,
    output reg busy,
    output reg done
);
    reg [15:0] cnt_ff;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_ff <= load_val;
                busy <= 1'b1;
            end else if (busy) begin
                if (cnt_ff == 16'h0001) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_ff <= cnt_ff - 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ==== hdl/pls_oc_detect.v ====
`timescale 1ns/100ps
`default_nettype none
`include "pls_defs.vh"
// ==========================================================
// Counts consecutive high-then-low limit pairs
module pls_oc_detect (
    input wire clk_sys,
    input wire resetn,
    input wire clr,
    input wire cbc_high,
    input wire cbc_low,
    input wire pwm_cycle,
    output reg oc_trip
);
    reg [2:0] pairs_ff;
    reg hi_seen_ff;
    reg pair_seen_ff;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pairs_ff <= 3'h0;
            hi_seen_ff <= 1'b0;
            pair_seen_ff <= 1'b0;
            oc_trip <= 1'b0;
        end else begin
            oc_trip <= 1'b0;
            if (clr) begin
                pairs_ff <= 3'h0;
                hi_seen_ff <= 1'b0;
                pair_seen_ff <= 1'b0;
            end else if (cbc_high) begin
                hi_seen_ff <= 1'b1;
            end else if (cbc_low && hi_seen_ff) begin
                hi_seen_ff <= 1'b0;
                pair_seen_ff <= 1'b1;
                // A fourth consecutive pair declares over-current
                if (pairs_ff == `PLS_OC_PAIRS - 3'h1) begin
                    oc_trip <= 1'b1; // [RULE17]
                    pairs_ff <= 3'h0;
                end else begin
                    pairs_ff <= pairs_ff + 3'h1;
                end
            end else if (pwm_cycle) begin
                // Only a PWM cycle with no completed pair and no pending high breaks the run
                if (!pair_seen_ff && !hi_seen_ff)
                    pairs_ff <= 3'h0;
                pair_seen_ff <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/pls_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Sequencing checks at the supervisor pins
module pls_checker (
    input wire clk_sys,
    input wire resetn,
    input wire input_undervoltage_lockout,
    input wire input_overvoltage_lockout,
    input wire hard_thermal_shutdown,
    input wire soft_thermal_shutdown,
    input wire output_overvoltage,
    input wire internal_enable,
    input wire freq_check_done,
    input wire freq_resistor_valid,
    input wire bias_enable,
    input wire aux_enable,
    input wire main_enable,
    input wire freq_check_start
);
    wire lock = input_undervoltage_lockout | input_overvoltage_lockout;
    reg latch_ff;
    // Tracks overvoltage latch only; a level 1 or 2 restart inside it is not expected
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) latch_ff <= 1'h0;
        else if (!internal_enable) latch_ff <= 1'h0;
        else if (main_enable && output_overvoltage) latch_ff <= 1'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_hic_trip; main_enable && soft_thermal_shutdown; endsequence
    sequence s_bad_res; freq_check_done && !freq_resistor_valid && !main_enable; endsequence
    chk_lockout_stop: assert property (lock |=> !bias_enable && !aux_enable && !main_enable)
        else $error("lockout left an output on");
    chk_lockout_hold: assert property ($rose(bias_enable) |-> !$past(lock))
        else $error("bias rose during lockout");
    chk_reset_stop: assert property (hard_thermal_shutdown |=> !bias_enable && !aux_enable)
        else $error("hard thermal kept bias on");
    chk_latch_hold: assert property (latch_ff |-> !main_enable)
        else $error("latched converter came back");
    chk_ov_latch: assert property (main_enable && output_overvoltage |=> !main_enable)
        else $error("overvoltage kept converter on");
    chk_hic_off: assert property (s_hic_trip |=> !main_enable [*8])
        else $error("hiccup off period too short");
    chk_res_retry: assert property (s_bad_res |-> ##[1:4] freq_check_start)
        else $error("no new resistor check");
    chk_no_recheck: assert property (main_enable |-> !freq_check_start)
        else $error("resistor check while running");
endmodule
bind pls_supervisor pls_checker i_pls_checker (.*);
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pls_defs.vh"
module testbench;
    localparam int HIC = `PLS_HICCUP_CYC;
    localparam int BLK = `PLS_BLANK_CYC;
    reg clk_sys = 0, resetn = 0;
    reg input_undervoltage_lockout = 1, input_overvoltage_lockout = 1;
    reg bias_overcurrent = 0, bias_overvoltage = 0, bias_undervoltage = 0;
    reg aux_undervoltage = 0, hard_thermal_shutdown = 0, soft_thermal_shutdown = 0;
    reg output_undervoltage = 0, output_overvoltage = 0, sync_input_error = 0;
    reg cbc_limit_high = 0, cbc_limit_low = 0, pwm_cycle = 0, bias_power_good = 0;
    reg freq_resistor_valid = 0, freq_check_done = 0, internal_enable = 0;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
    reg reg_wr = 0, reg_rd = 0;
    wire [7:0] reg_rdata;
    wire bias_enable, aux_enable, main_enable, freq_check_start, irq;
    int error_cnt = 0, tests_run = 0, n, k;
    pls_supervisor i_pls_supervisor (.*);
    initial forever #25 clk_sys = ~clk_sys;
    // ======================================================
    // Tasks
    task end_of_test;
        $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input [7:0] s, input [7:0] e, input string nm);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    task cr(input [7:0] a, input [7:0] e, input string nm);
        @(posedge clk_sys);
        reg_addr <= a; reg_rd <= 1;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1 d = reg_rdata;
        chk(d, e, nm);
    endtask
    task setf(input int f, input bit v);
        @(posedge clk_sys);
        case (f)
            0: soft_thermal_shutdown <= v;
            1: output_undervoltage <= v;
            2: sync_input_error <= v;
            3: output_overvoltage <= v;
            4: hard_thermal_shutdown <= v;
            5: bias_overcurrent <= v;
            6: bias_overvoltage <= v;
            7: bias_undervoltage <= v;
            8: aux_undervoltage <= v;
            9: input_undervoltage_lockout <= v;
            10: input_overvoltage_lockout <= v;
            11: bias_power_good <= v;
            default: internal_enable <= v;
        endcase
    endtask
    // Counts edges until the chosen output reaches v; bounded so a hang ends the run
    task wt(input int s, input bit v);
        n = 0;
        // Settle first so a pulse launched on the calling edge is not missed
        #1;
        while ((s == 0 ? main_enable : s == 1 ? bias_enable : freq_check_start) !== v) begin
            @(posedge clk_sys); #1;
            if (++n > 3000) begin error_cnt++; end_of_test; end
        end
    endtask
    task res(input bit v);
        @(posedge clk_sys);
        freq_check_done <= 1; freq_resistor_valid <= v;
        @(posedge clk_sys);
        freq_check_done <= 0;
    endtask
    task pr(input bit h);
        @(posedge clk_sys) cbc_limit_high <= h;
        @(posedge clk_sys) begin cbc_limit_high <= 0; cbc_limit_low <= h; end
        @(posedge clk_sys) begin cbc_limit_low <= 0; pwm_cycle <= 1; end
        @(posedge clk_sys) pwm_cycle <= 0;
    endtask
    task up;
        wt(2, 1); res(1); wt(0, 1);
    endtask
    task step(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask
    // ======================================================
    // Main sequence
    initial begin
        step(20);
        resetn <= 1;
        step(5); chk(bias_enable, 0, "bias lock");
        setf(9, 0); step(5); chk(bias_enable, 0, "bias input_overvoltage_lockout");
        setf(10, 0); wt(1, 1); chk(aux_enable, 1, "aux up");
        wr(`PLS_ADDR_IRQ, 8'h3F);
        cr(`PLS_ADDR_CTRL, `PLS_CTRL_RST, "ctrl rst");
        cr(`PLS_ADDR_MASK, 8'h00, "mask rst");
        wr(8'h20, 8'hFF); cr(8'h20, 8'h00, "unmapped");
        setf(11, 1); setf(12, 1); wt(2, 1); res(0); wt(2, 1);
        chk(main_enable, 0, "main bad res");
        cr(`PLS_ADDR_IRQ, 8'h01, "res flag");
        chk(irq, 0, "irq masked");
        wr(`PLS_ADDR_MASK, 8'h01); step(3); chk(irq, 1, "irq on");
        wr(`PLS_ADDR_IRQ, 8'h01); step(3); chk(irq, 0, "irq clr");
        res(1); wt(0, 1); cr(`PLS_ADDR_STATE, 8'h05, "run");
        cr(`PLS_ADDR_STAT, 8'h09, "status run");
        res(0); step(2); cr(`PLS_ADDR_IRQ, 8'h00, "no recheck");
        for (k = 0; k < 3; k++) begin
            setf(k, 1); wt(0, 0); wt(0, 1);
            chk(n >= HIC - 1 && n <= HIC + 2, 1, "hiccup off");
            wt(0, 0); chk(n <= 2, 1, "retrip");
            setf(k, 0); wt(0, 1); step(10); chk(main_enable, 1, "resume");
            cr(`PLS_ADDR_IRQ, 8'h20, "hic flag");
            wr(`PLS_ADDR_IRQ, 8'h20);
        end
        setf(0, 1); wt(0, 0); setf(12, 0); step(HIC + 50);
        chk(main_enable, 0, "host stop");
        cr(`PLS_ADDR_STATE, 8'h04, "host ready");
        setf(0, 0); setf(12, 1); wt(0, 1); wr(`PLS_ADDR_IRQ, 8'h20);
        wr(`PLS_ADDR_CTRL, 8'h01); cr(`PLS_ADDR_CTRL, 8'h01, "ctrl");
        for (k = 1; k < 4; k++) begin
            setf(k, 1); wt(0, 0); setf(k, 0); step(HIC + 50);
            chk(main_enable, 0, "latched");
            cr(`PLS_ADDR_STATE, 8'h06, "latch st");
            cr(`PLS_ADDR_IRQ, 8'h10, "latch flag");
            wr(`PLS_ADDR_IRQ, 8'h10);
            setf(12, 0); step(3); setf(12, 1); wt(0, 1);
        end
        repeat (3) pr(1);
        pr(0);
        repeat (3) pr(1);
        step(3); chk(main_enable, 1, "oc 3 pairs");
        pr(1); step(3); chk(main_enable, 0, "oc trip");
        cr(`PLS_ADDR_IRQ, 8'h12, "oc flag");
        chk(d & 8'h02, 8'h02, "oc bit");
        wr(`PLS_ADDR_IRQ, 8'h3F); setf(12, 0); step(3); setf(12, 1); wt(0, 1);
        for (k = 4; k < 9; k++) begin
            setf(k, 1); wt(1, 0); chk(aux_enable | main_enable, 0, "l2 off");
            setf(k, 0); wt(1, 1);
            chk(n >= BLK - 4 && n <= BLK + 2, 1, "blanking");
            up;
        end
        setf(9, 1); step(2); chk(main_enable | bias_enable, 0, "l1 run");
        setf(9, 0); wt(1, 1); up;
        end_of_test;
    end
endmodule
`default_nettype wire
